// ===== hw/ldo_and_fade_control_regs.sv
/*
  Write-only control registers for two regulators and the backlight fade engine.
  Assumes writes arrive already decoded from the single-wire interface.
*/
`timescale 1ns/1ps
module ldo_and_fade_control_regs
  import lmu_pkg::*;
#(
  parameter int UNIT = UNIT_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [2:0] i_addr,
  input wire logic [5:0] i_data,
  output logic [3:0] o_first_regulator_voltage_code,
  output logic [2:0] o_second_regulator_voltage_code,
  output logic o_first_regulator_on,
  output logic o_second_regulator_on,
  output logic [8:0] o_first_regulator_mv10,
  output logic [8:0] o_second_regulator_mv10,
  output logic [4:0] o_sink_current_code,
  output logic o_fade_busy
);
  logic [3:0] reg1_reg;
  logic [2:0] reg2_reg;
  logic fade_en_reg;
  logic [1:0] rate_reg;
  logic [4:0] target_reg;
  logic [4:0] applied_reg;
  fade_state_t state_reg;
  logic [8:0] mv1;
  logic [8:0] mv2;
  logic start;
  step_if st ();

  // -------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------
  // write-only, no read path
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      reg1_reg <= 4'h0;
      reg2_reg <= 3'h0;
    end else if (i_wr && i_addr == ADDR_REG1) begin
      reg1_reg <= i_data[3:0];
    end else if (i_wr && i_addr == ADDR_REG2) begin
      reg2_reg <= i_data[2:0];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fade_en_reg <= 1'b0;
      rate_reg <= 2'h0;
    end else if (i_wr && i_addr == ADDR_FADE) begin
      fade_en_reg <= i_data[FADE_EN_BIT];
      rate_reg <= i_data[RATE_MSB:RATE_LSB];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      target_reg <= 5'h00;
    end else if (i_wr && i_addr == ADDR_CURRENT && state_reg == FADE_IDLE) begin
      target_reg <= i_data[CODE_W-1:0];
    end
  end

  // -------------------------------------------------------------
  // Fade engine
  // -------------------------------------------------------------
  assign start = i_wr && i_addr == ADDR_CURRENT && state_reg == FADE_IDLE && fade_en_reg &&
                 i_data[CODE_W-1:0] != applied_reg;
  assign st.restart = start;
  assign st.rate = rate_reg;

  step_timer #(.UNIT(UNIT)) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .st(st)
  );

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= FADE_IDLE;
      applied_reg <= 5'h00;
    end else begin
      case (state_reg)
        FADE_IDLE: begin
          if (start) begin
            state_reg <= FADE_RUN;
          end else if (i_wr && i_addr == ADDR_CURRENT) begin
            applied_reg <= i_data[CODE_W-1:0];
          end
        end
        FADE_RUN: begin
          if (!fade_en_reg) begin
            applied_reg <= target_reg;
            state_reg <= FADE_IDLE;
          end else if (st.tick) begin
            if (applied_reg < target_reg) begin
              applied_reg <= applied_reg + 5'h01;
            end else begin
              applied_reg <= applied_reg - 5'h01;
            end
            if (applied_reg + 5'h01 == target_reg || applied_reg - 5'h01 == target_reg) begin
              state_reg <= FADE_IDLE;
            end
          end
        end
        default: begin
          state_reg <= FADE_IDLE;
        end
      endcase
    end
  end

  reg1_decode u_dec (
    .i_code1(reg1_reg),
    .i_code2(reg2_reg),
    .o_mv1(mv1),
    .o_mv2(mv2)
  );

  // -------------------------------------------------------------
  // Registered outputs
  // -------------------------------------------------------------
  // one shared code
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_first_regulator_voltage_code <= 4'h0;
      o_second_regulator_voltage_code <= 3'h0;
      o_first_regulator_on <= 1'b0;
      o_second_regulator_on <= 1'b0;
      o_first_regulator_mv10 <= 9'h000;
      o_second_regulator_mv10 <= 9'h000;
      o_sink_current_code <= 5'h00;
      o_fade_busy <= 1'b0;
    end else begin
      o_first_regulator_voltage_code <= reg1_reg;
      o_second_regulator_voltage_code <= reg2_reg;
      o_first_regulator_on <= reg1_reg != 4'h0;
      o_second_regulator_on <= reg2_reg != 3'h0;
      o_first_regulator_mv10 <= mv1;
      o_second_regulator_mv10 <= mv2;
      o_sink_current_code <= applied_reg;
      o_fade_busy <= state_reg == FADE_RUN;
    end
  end
endmodule

// ===== hw/lmu_pkg.sv
/*
  Constants shared by the regulator and fade control register bank.
  Assumes a decoded single-wire write port (address, data, one-cycle strobe) outside.
*/
// Operation
// - First regulator 4-bit code: 0 off, 1-10 3.3V to 2.4V, 11 2.2V, 12-15 1.8V to 1.5V.
// - Second regulator 3-bit code: 0 off, 1-7 give 1.8V down to 1.2V.
// - Rate field 00/01/10/11 gives 32/24/16/8 ms per fade step.
// - A fade takes as many one-count steps as the code difference, except between codes 0 and 31, where it stops after one step.
// - With fading on, a new current code starts stepping toward the target.
// - Current code writes during a fade are ignored.
// - Clearing fade enable mid-fade applies the target at once.
// - With fading off, a written current code applies at once.
// - Rate writes apply at any time, also to the running fade.
// - Fade register: D0 enable, D2:D1 rate select.
// - Fade time equals step count times the step interval.
// - Registers are write-only; host writes zeros to unused upper bits.
// - One shared 5-bit current code drives every enabled sink; the bank has no sink enable register and ignores ADDR_SINK_EN writes.
package lmu_pkg;
  localparam logic [2:0] ADDR_CURRENT = 3'h0;
  localparam logic [2:0] ADDR_SINK_EN = 3'h1;
  localparam logic [2:0] ADDR_REG1 = 3'h2;
  localparam logic [2:0] ADDR_REG2 = 3'h3;
  localparam logic [2:0] ADDR_FADE = 3'h4;
  localparam int DATA_W = 6;
  localparam int CODE_W = 5;
  localparam int SINKS = 4;
  localparam int FADE_EN_BIT = 0;
  localparam int RATE_LSB = 1;
  localparam int RATE_MSB = 2;
  localparam logic [5:0] RESET_VALUE = 6'h00;
  localparam int CLK_HZ = 50000000;
  localparam int STEP_UNIT_MS = 8;
  localparam int UNIT_CYCLES = (CLK_HZ / 1000) * STEP_UNIT_MS;
  // Regulator output in tens of millivolts, 0 meaning off.
  localparam logic [8:0] REG1_MV10_OFF = 9'h000;
  typedef enum logic [1:0] {
    FADE_IDLE = 2'b00,
    FADE_RUN = 2'b01
  } fade_state_t;
endpackage

// ===== hw/reg1_decode.sv
/*
  Voltage code decoder for both regulators, in tens of millivolts.
  Assumes codes come from registers on the same clock.
*/
`timescale 1ns/1ps
module reg1_decode
  import lmu_pkg::*;
(
  input wire logic [3:0] i_code1,
  input wire logic [2:0] i_code2,
  output logic [8:0] o_mv1,
  output logic [8:0] o_mv2
);
  always_comb begin
    if (i_code1 == 4'h0) begin
      o_mv1 = REG1_MV10_OFF;
    end else if (i_code1 <= 4'hA) begin
      o_mv1 = 9'(340 - 10 * int'(i_code1));
    end else if (i_code1 == 4'hB) begin
      o_mv1 = 9'h0DC;
    end else begin
      o_mv1 = 9'(300 - 10 * int'(i_code1));
    end
  end

  always_comb begin
    if (i_code2 == 3'h0) begin
      o_mv2 = REG1_MV10_OFF;
    end else begin
      o_mv2 = 9'(190 - 10 * int'(i_code2));
    end
  end
endmodule

// ===== hw/step_if.sv
/*
  Carrier between fade engine and step timer.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface step_if;
  logic restart;
  logic [1:0] rate;
  logic tick;
  modport engine (output restart, output rate, input tick);
  modport timer (input restart, input rate, output tick);
endinterface

// ===== hw/step_timer.sv
/*
  Fade step interval timer: emits one tick per selected interval.
  Assumes a restart pulse at the start of each fade.
*/
`timescale 1ns/1ps
module step_timer
  import lmu_pkg::*;
#(
  parameter int UNIT = UNIT_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  step_if.timer st
);
  logic [23:0] count_reg;
  logic [23:0] limit;

  // -------------------------------------------------------------
  // Interval select
  // -------------------------------------------------------------
  // rate to interval
  always_comb begin
    limit = 24'((4 - int'(st.rate)) * UNIT - 1);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= 24'h000000;
      st.tick <= 1'b0;
    end else if (st.restart) begin
      count_reg <= 24'h000000;
      st.tick <= 1'b0;
    end else if (count_reg >= limit) begin
      count_reg <= 24'h000000;
      st.tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 24'h000001;
      st.tick <= 1'b0;
    end
  end
endmodule

// ===== testbench/host_model.sv
/* Host model that issues decoded register writes to the bank.
   Assumes the bank samples the strobe on the rising clock edge. */
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk_sys,
  output logic o_wr,
  output logic [2:0] o_addr,
  output logic [5:0] o_data
);
  initial begin
    o_wr = 1'b0;
    o_addr = 3'h7;
    o_data = 6'h3F;
  end
  task automatic wr_reg(input logic [2:0] a, input logic [5:0] d);
    @(negedge i_clk_sys);
    o_wr = 1'b1;
    o_addr = a;
    o_data = d;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_addr = ~a;
    o_data = ~d;
  endtask
endmodule

// ===== testbench/ldo_and_fade_control_regs_test.sv
/* Self-checking bench for the regulator and fade register bank.
   Assumes the host model and a short step unit of ten cycles. */
`timescale 1ns/1ps
module ldo_and_fade_control_regs_test;
  import lmu_pkg::*;
  localparam int U = 10;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic wr, on1, on2, busy;
  logic [2:0] addr, c2;
  logic [5:0] data;
  logic [3:0] c1;
  logic [8:0] mv1, mv2;
  logic [4:0] cur;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  always #10 i_clk_sys = ~i_clk_sys;
  host_model i_host (.i_clk_sys, .o_wr(wr), .o_addr(addr), .o_data(data));
  ldo_and_fade_control_regs #(.UNIT(U)) i_dut (.i_clk_sys, .i_rst, .i_wr(wr), .i_addr(addr), .i_data(data),
    .o_first_regulator_voltage_code(c1), .o_second_regulator_voltage_code(c2), .o_first_regulator_on(on1),
    .o_second_regulator_on(on2), .o_first_regulator_mv10(mv1), .o_second_regulator_mv10(mv2),
    .o_sink_current_code(cur), .o_fade_busy(busy));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr_set(input logic [2:0] a, input logic [5:0] d);
    i_host.wr_reg(a, d);
    repeat (3) @(negedge i_clk_sys);
  endtask
  task automatic wait_idle(output int k);
    for (k = 1; k < 3000; k++) begin
      @(negedge i_clk_sys);
      if (k > 3 && busy === 1'b0) break;
    end
    if (k == 3000) begin
      bad_count++;
      end_sim();
    end
  endtask
  initial begin
    repeat (6) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk("reset", 9'h000, {cur, busy, on1, on2, c2 != 3'h0});
    for (int c = 0; c < 16; c++) begin
      wr_set(ADDR_REG1, 6'(c));
      wr_set(ADDR_REG2, 6'(c % 8));
      chk("code1", 9'(c), {on1 != (c != 0), c1});
      chk("mv1", c == 0 ? 9'h000 : 9'(c < 11 ? 340 - 10 * c : c == 11 ? 220 : 300 - 10 * c), mv1);
      chk("code2", 9'(c % 8), {on2 != (c % 8 != 0), c2});
      chk("mv2", c % 8 == 0 ? 9'h000 : 9'(190 - 10 * (c % 8)), mv2);
    end
    wr_set(ADDR_SINK_EN, 6'h0F);
    wr_set(3'h5, 6'h00);
    chk("ignored", 9'h07F, {c1, c2});
    wr_set(ADDR_FADE, 6'h00);
    wr_set(ADDR_CURRENT, 6'h14);
    chk("direct", 9'h014, cur);
    for (int r = 0; r < 4; r++) begin
      wr_set(ADDR_FADE, 6'(r * 2 + 1));
      i_host.wr_reg(ADDR_CURRENT, (r % 2) ? 6'h14 : 6'h11);
      wait_idle(n);
      chk("fade_time", 9'h001, 9'(n >= 3 * (4 - r) * U && n <= 3 * (4 - r) * U + 5));
      chk("fade_end", (r % 2) ? 9'h014 : 9'h011, cur);
    end
    i_host.wr_reg(ADDR_CURRENT, 6'h17);
    repeat (5) @(negedge i_clk_sys);
    i_host.wr_reg(ADDR_CURRENT, 6'h00);
    wait_idle(n);
    chk("refused", 9'h017, cur);
    wr_set(ADDR_FADE, 6'h01);
    i_host.wr_reg(ADDR_CURRENT, 6'h15);
    i_host.wr_reg(ADDR_FADE, 6'h07);
    wait_idle(n);
    chk("rate_change", 9'h001, 9'(n >= U && n < 6 * U));
    i_host.wr_reg(ADDR_FADE, 6'h01);
    i_host.wr_reg(ADDR_CURRENT, 6'h05);
    repeat (50) @(negedge i_clk_sys);
    wr_set(ADDR_FADE, 6'h00);
    chk("cancel", 9'h005, {busy, cur});
    i_rst = 1'b1;
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk("rerun_reset", 9'h000, {cur, c1});
    end_sim();
  end
endmodule

// ===== testbench/ldo_fade_assertions.sv
/* Port checker for the regulator and fade register bank.
   Assumes it is bound to the bank and sees only its ports. */
`timescale 1ns/1ps
module ldo_fade_assertions
  import lmu_pkg::*;
#(
  parameter int UNIT = UNIT_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [2:0] i_addr,
  input wire logic [5:0] i_data,
  input wire logic [3:0] o_first_regulator_voltage_code,
  input wire logic [2:0] o_second_regulator_voltage_code,
  input wire logic o_first_regulator_on,
  input wire logic o_second_regulator_on,
  input wire logic [4:0] o_sink_current_code,
  input wire logic o_fade_busy
);
  logic fen_reg;
  logic [4:0] tgt_reg;
  logic [4:0] prev_reg;
  int gap_reg;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fen_reg <= 1'b0;
      tgt_reg <= 5'h00;
    end else if (i_wr && i_addr == ADDR_FADE) begin
      fen_reg <= i_data[FADE_EN_BIT];
    end else if (i_wr && i_addr == ADDR_CURRENT && !o_fade_busy) begin
      tgt_reg <= i_data[4:0];
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      prev_reg <= 5'h00;
      gap_reg <= 0;
    end else begin
      prev_reg <= o_sink_current_code;
      gap_reg <= (o_sink_current_code != prev_reg) ? 0 : gap_reg + 1;
    end
  end
  property p_reg1;
    i_wr && i_addr == ADDR_REG1 ##1 !i_wr [*2] |-> ##1 o_first_regulator_voltage_code == $past(i_data[3:0], 3)
      && o_first_regulator_on == ($past(i_data[3:0], 3) != 4'h0);
  endproperty
  a_reg1: assert property (p_reg1) else $error("first regulator code wrong");
  property p_reg2;
    i_wr && i_addr == ADDR_REG2 ##1 !i_wr [*2] |-> ##1 o_second_regulator_voltage_code == $past(i_data[2:0], 3)
      && o_second_regulator_on == ($past(i_data[2:0], 3) != 3'h0);
  endproperty
  a_reg2: assert property (p_reg2) else $error("second regulator code wrong");
  property p_direct;
    !fen_reg && i_wr && i_addr == ADDR_CURRENT ##1 !i_wr [*2] |-> ##1 o_sink_current_code == $past(i_data[4:0], 3);
  endproperty
  a_direct: assert property (p_direct) else $error("direct current apply wrong");
  property p_busy_go;
    fen_reg && !o_fade_busy && i_wr && i_addr == ADDR_CURRENT && i_data[4:0] != o_sink_current_code
      |-> ##[1:3] o_fade_busy;
  endproperty
  a_busy_go: assert property (p_busy_go) else $error("fade did not start");
  property p_step;
    o_fade_busy && o_sink_current_code != prev_reg |-> o_sink_current_code - prev_reg == 5'h01
      || prev_reg - o_sink_current_code == 5'h01;
  endproperty
  a_step: assert property (p_step) else $error("fade step not one count");
  property p_gap;
    o_fade_busy && o_sink_current_code != prev_reg |-> gap_reg >= UNIT - 2;
  endproperty
  a_gap: assert property (p_gap) else $error("fade step too early");
  property p_cancel;
    fen_reg && o_fade_busy && i_wr && i_addr == ADDR_FADE && !i_data[FADE_EN_BIT]
      |-> ##3 !o_fade_busy && o_sink_current_code == tgt_reg;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel did not apply target");
  property p_reset;
    disable iff (1'b0) i_rst ##1 i_rst |-> o_sink_current_code == 5'h00 && !o_fade_busy && !o_first_regulator_on
      && !o_second_regulator_on;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared in reset");
  c_fade: cover property (fen_reg && $rose(o_fade_busy));
  c_done: cover property ($fell(o_fade_busy));
  c_cancel: cover property (i_wr && i_addr == ADDR_FADE && o_fade_busy);
endmodule
bind ldo_and_fade_control_regs ldo_fade_assertions #(.UNIT(UNIT)) i_chk (.i_clk_sys, .i_rst, .i_wr, .i_addr,
  .i_data, .o_first_regulator_voltage_code, .o_second_regulator_voltage_code, .o_first_regulator_on,
  .o_second_regulator_on, .o_sink_current_code, .o_fade_busy);
